// >>> cat_defines.vh
`ifndef CAT_DEFINES_VH
`define CAT_DEFINES_VH

// Register byte addresses
`define CAT_ADDR_CNTLO      8'h00
`define CAT_ADDR_CNTHI      8'h04
`define CAT_ADDR_MODE       8'h08
`define CAT_ADDR_CTRL       8'h0c
`define CAT_ADDR_CCBASE     8'h20
`define CAT_ADDR_IOEN       8'h10
`define CAT_ADDR_IOPIN      8'h14
`define CAT_ADDR_CCEND      8'h50
// Mode register fields
`define CAT_MODE_OVFIE      0
`define CAT_MODE_TB_LO      1
`define CAT_MODE_TB_HI      3
`define CAT_MODE_WDOG       5
`define CAT_MODE_IDLSUS     7
// Control register fields
`define CAT_CTRL_OVF        7
`define CAT_CTRL_ARRIE      0
// Reset values
`define CAT_MODE_RESET      8'h20
// Timebase codes
`define CAT_TB_DIV12        3'h0
`define CAT_TB_DIV4         3'h1
`define CAT_TB_T0OVF        3'h2
`define CAT_TB_EXTIN        3'h3
`define CAT_TB_SYSCLK       3'h4
`define CAT_TB_XOSC8        3'h5
// Divider counts
`define CAT_DIV12           4'hc
`define CAT_DIV4            4'h4
`define CAT_DIV8            4'h8
// Capture/compare modules
`define CAT_NMOD            6
`define CAT_WDOG_MOD        5

`endif

// >>> cat_tick_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "cat_defines.vh"

module cat_tick_gen (
	// Clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// Selection
	input  wire [2:0] tbSel,
	// Timebase sources
	input  wire       t0Ovf,
	input  wire       extCountIn,
	input  wire       extOscIn,
	// Tick out
	output reg        tick_q
);

	reg  [3:0] div12_q;
	reg  [1:0] div4_q;
	reg        extPrev_q;
	reg        xoscS1_q;
	reg        xoscS2_q;
	reg        xoscPrev_q;
	reg  [2:0] xdiv_q;
	reg        tick_d;
	wire       xoscRise;

	assign xoscRise = xoscS2_q & ~xoscPrev_q;

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div12_q    <= 4'h0;
			div4_q     <= 2'h0;
			extPrev_q  <= 1'b1;
			xoscS1_q   <= 1'b0;
			xoscS2_q   <= 1'b0;
			xoscPrev_q <= 1'b0;
			xdiv_q     <= 3'h0;
			tick_q     <= 1'b0;
		end else begin
			div12_q    <= (div12_q == `CAT_DIV12 - 4'h1) ? 4'h0 : div12_q + 4'h1;
			div4_q     <= div4_q + 2'h1;
			extPrev_q  <= extCountIn;
			xoscS1_q   <= extOscIn;
			xoscS2_q   <= xoscS1_q;
			xoscPrev_q <= xoscS2_q;
			if (xoscRise)
				xdiv_q <= xdiv_q + 3'h1;
			tick_q     <= tick_d;
		end
	end

	always @* begin
		case (tbSel)
		`CAT_TB_DIV12:  tick_d = (div12_q == 4'h0);
		`CAT_TB_DIV4:   tick_d = (div4_q == 2'h0);
		`CAT_TB_T0OVF:  tick_d = t0Ovf;
		`CAT_TB_EXTIN:  tick_d = extPrev_q & ~extCountIn;
		`CAT_TB_SYSCLK: tick_d = 1'b1;
		`CAT_TB_XOSC8:  tick_d = xoscRise & (xdiv_q == 3'h7);
		default:        tick_d = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// >>> cat_ccm_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "cat_defines.vh"

module cat_ccm_bank (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// Byte write port
	input  wire        wrEn,
	input  wire [3:0]  wrIdx,
	input  wire [7:0]  wrData,
	// Byte read port
	input  wire [3:0]  rdIdx,
	output wire [7:0]  rdData
);

	// Six 16-bit values kept as twelve bytes, low byte at even index
	reg [7:0] ccByte_q [0:11];
	integer   i;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < 12; i = i + 1)
				ccByte_q[i] <= 8'h00;
		end else if (wrEn && wrIdx < 4'hc) begin
			ccByte_q[wrIdx] <= wrData;
		end
	end

	assign rdData = (rdIdx < 4'hc) ? ccByte_q[rdIdx] : 8'h00;

endmodule
`default_nettype wire

// >>> cat_counter_array.v
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cat_defines.vh"

module cat_counter_array (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// System signals
	input  wire        cpuIdle,
	input  wire        globalIrqEnable,
	input  wire        t0Ovf,
	input  wire        extCountIn,
	input  wire        extOscIn,
	input  wire [5:0]  moduleIoIn,
	// Outputs
	output reg         irqReq,
	output reg  [5:0]  moduleIoOut,
	output reg  [5:0]  moduleIoOe,
	output reg         watchdogMode
);

	reg  [15:0] count_q;
	reg  [7:0]  snapHi_q;
	reg  [7:0]  mode_q;
	reg         ovf_q;
	reg         arrIe_q;
	reg  [5:0]  ioEn_q;
	reg         wrPend_q;
	reg  [7:0]  wrAddr_q;
	wire        tick;
	wire        run;
	wire        wrap;
	wire        acc;
	wire [7:0]  ccRd;
	wire        ccWr;
	wire [3:0]  ccWrIdx;
	wire [3:0]  ccRdIdx;
	wire        wdogOn;
	wire        wrCntLo;
	wire        wrCntHi;
	wire        wrMode;
	wire        wrCtrl;
	wire        wrIoEn;
	wire        rdAcc;
	wire        rdCntLo;
	reg  [31:0] rd_d;
	reg  [15:0] count_d;
	reg  [7:0]  mode_d;
	reg         ovf_d;
	reg         arrIe_d;
	reg  [5:0]  ioEn_d;
	reg         irqReq_d;

	// Byte index of a capture/compare register
	function [3:0] ccIndex;
		input [7:0] a;
		reg   [7:0] off;
		begin
			off = a - `CAT_ADDR_CCBASE;
			ccIndex = off[5:2];
		end
	endfunction

	// Address lies inside the capture/compare window
	function isCcAddr;
		input [7:0] a;
		begin
			isCcAddr = (a >= `CAT_ADDR_CCBASE) && (a < `CAT_ADDR_CCEND);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	cat_tick_gen u_tick (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.tbSel      (mode_q[`CAT_MODE_TB_HI:`CAT_MODE_TB_LO]),
		.t0Ovf      (t0Ovf),
		.extCountIn (extCountIn),
		.extOscIn   (extOscIn),
		.tick_q     (tick)
	);

	assign run  = tick & ~(cpuIdle & mode_q[`CAT_MODE_IDLSUS]);
	assign wrap = run & (count_q == 16'hffff);

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite: writes take effect in the data phase, zero wait states
	assign acc = hsel & hready & htrans[1];
	assign rdAcc   = acc & ~hwrite;
	assign rdCntLo = rdAcc & (haddr[7:0] == `CAT_ADDR_CNTLO);
	assign wrCntLo = wrPend_q & (wrAddr_q == `CAT_ADDR_CNTLO);
	assign wrCntHi = wrPend_q & (wrAddr_q == `CAT_ADDR_CNTHI);
	assign wrMode  = wrPend_q & (wrAddr_q == `CAT_ADDR_MODE);
	assign wrCtrl  = wrPend_q & (wrAddr_q == `CAT_ADDR_CTRL);
	assign wrIoEn  = wrPend_q & (wrAddr_q == `CAT_ADDR_IOEN);
	assign wdogOn  = mode_q[`CAT_MODE_WDOG];
	assign ccWr    = wrPend_q & isCcAddr(wrAddr_q);
	assign ccWrIdx = ccIndex(wrAddr_q);
	assign ccRdIdx = ccIndex(haddr[7:0]);

	cat_ccm_bank u_ccm (
		.clk    (clk),
		.sys_rst(sys_rst),
		.wrEn   (ccWr),
		.wrIdx  (ccWrIdx),
		.wrData (hwdata[7:0]),
		.rdIdx  (ccRdIdx),
		.rdData (ccRd)
	);

	always @* begin
		rd_d = 32'h0;
		case (haddr[7:0])
		`CAT_ADDR_CNTLO: rd_d = {24'h0, count_q[7:0]};
		`CAT_ADDR_CNTHI: rd_d = {24'h0, snapHi_q};
		`CAT_ADDR_MODE:  rd_d = {24'h0, mode_q};
		`CAT_ADDR_CTRL:  rd_d = {24'h0, ovf_q, 6'h0, arrIe_q};
		`CAT_ADDR_IOEN:  rd_d = {26'h0, ioEn_q};
		`CAT_ADDR_IOPIN: rd_d = {26'h0, moduleIoIn};
		default: begin
			if (isCcAddr(haddr[7:0]))
				rd_d = {24'h0, ccRd};
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next values of the software-visible registers
	always @* begin
		count_d = count_q;
		if (run)
			count_d = count_q + 16'h0001;
		// Watchdog duty locks the count against software
		if (wrCntLo && !wdogOn)
			count_d[7:0] = hwdata[7:0];
		if (wrCntHi && !wdogOn)
			count_d[15:8] = hwdata[7:0];
	end

	always @* begin
		mode_d = mode_q;
		if (wrMode) begin
			if (wdogOn)
				mode_d[`CAT_MODE_WDOG] = hwdata[`CAT_MODE_WDOG];
			else
				mode_d = hwdata[7:0];
		end
	end

	// A wrap in the cycle of a software clear keeps the flag set
	always @* begin
		ovf_d   = ovf_q;
		arrIe_d = arrIe_q;
		if (wrCtrl) begin
			arrIe_d = hwdata[`CAT_CTRL_ARRIE];
			if (!hwdata[`CAT_CTRL_OVF])
				ovf_d = 1'b0;
		end
		if (wrap)
			ovf_d = 1'b1;
	end

	always @* begin
		ioEn_d = ioEn_q;
		if (wrIoEn)
			ioEn_d = hwdata[5:0];
	end

	// Wrap is folded in so the request does not lag the flag
	always @* begin
		irqReq_d = (ovf_q | wrap) & mode_q[`CAT_MODE_OVFIE];
		irqReq_d = irqReq_d & arrIe_q & globalIrqEnable;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPend_q <= acc & hwrite;
			if (acc)
				wrAddr_q <= haddr[7:0];
		end
	end

	// Bus response: always ready, always OKAY
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data and high-byte snapshot
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata   <= 32'h0;
			snapHi_q <= 8'h00;
		end else begin
			if (rdAcc)
				hrdata <= rd_d;
			if (rdCntLo)
				snapHi_q <= count_q[15:8];
		end
	end

	// Shared counter
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			count_q <= 16'h0000;
		else
			count_q <= count_d;
	end

	// Mode register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			mode_q <= `CAT_MODE_RESET;
		else
			mode_q <= mode_d;
	end

	// Control register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_q   <= 1'b0;
			arrIe_q <= 1'b0;
		end else begin
			ovf_q   <= ovf_d;
			arrIe_q <= arrIe_d;
		end
	end

	// Line enables
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ioEn_q <= 6'h00;
		else
			ioEn_q <= ioEn_d;
	end

	// Registered pin outputs
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqReq       <= 1'b0;
			moduleIoOut  <= 6'h00;
			moduleIoOe   <= 6'h00;
			watchdogMode <= 1'b1;
		end else begin
			irqReq       <= irqReq_d;
			moduleIoOe   <= ioEn_q;
			moduleIoOut  <= 6'h00;
			watchdogMode <= wdogOn;
		end
	end

endmodule
`default_nettype wire

// >>> cat_counter_array_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cat_counter_array_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Bus
	input wire logic        hsel,
	input wire logic        hwrite,
	input wire logic [1:0]  htrans,
	input wire logic [31:0] haddr,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// System
	input wire logic        globalIrqEnable,
	input wire logic        irqReq,
	input wire logic [5:0]  moduleIoOut,
	input wire logic [5:0]  moduleIoOe,
	input wire logic        watchdogMode
);
	logic ctlWr_q;
	wire  ctlAddr = haddr[7:0] == 8'h08 || haddr[7:0] == 8'h0c;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Data phase of a mode or control write
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ctlWr_q <= 1'b0;
		else
			ctlWr_q <= hsel && htrans[1] && hwrite && ctlAddr;
	end
	sequence s_cntRd;
		hsel && htrans[1] && !hwrite && haddr[7:3] == 5'h0;
	endsequence
	sequence s_irqHeld;
		irqReq && globalIrqEnable && !ctlWr_q && !$past(ctlWr_q);
	endsequence
	property p_bus;
		hresp == 1'b0 && hreadyout == 1'b1;
	endproperty
	property p_wdogSet;
		$past(sys_rst) |-> watchdogMode;
	endproperty
	property p_ioOeRst;
		$past(sys_rst) |-> moduleIoOe == 6'h0;
	endproperty
	property p_ioOut;
		moduleIoOut == 6'h0;
	endproperty
	property p_irqGlobal;
		!globalIrqEnable |=> !irqReq;
	endproperty
	property p_irqHold;
		s_irqHeld |=> irqReq;
	endproperty
	property p_wdogChg;
		$changed(watchdogMode) |-> $past(ctlWr_q) || $past(ctlWr_q, 2);
	endproperty
	property p_rdHigh;
		s_cntRd |=> hrdata[31:8] == 24'h0;
	endproperty
	a_bus:
		assert property (p_bus) else $error("bus answer wrong");
	a_wdogSet:
		assert property (p_wdogSet) else $error("watchdog off at reset");
	a_ioOeRst:
		assert property (p_ioOeRst) else $error("line enabled at reset");
	a_ioOut:
		assert property (p_ioOut) else $error("line output driven");
	a_irqGlobal:
		assert property (p_irqGlobal) else $error("irq without global");
	a_irqHold:
		assert property (p_irqHold) else $error("flag dropped by itself");
	a_wdogChg:
		assert property (p_wdogChg) else $error("watchdog changed alone");
	a_rdHigh:
		assert property (p_rdHigh) else $error("count byte too wide");
endmodule
bind cat_counter_array cat_counter_array_props u_props (.clk, .sys_rst,
	.hsel, .hwrite, .htrans, .haddr, .hrdata, .hreadyout, .hresp,
	.globalIrqEnable, .irqReq, .moduleIoOut, .moduleIoOe, .watchdogMode);
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, rdPh = 0;
	logic        cpuIdle = 0, globalIrqEnable = 0, t0Ovf = 0, irqReq;
	logic        extCountIn = 1, extOscIn = 0, watchdogMode, hreadyout;
	logic        hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [5:0]  moduleIoIn = 0, moduleIoOut, moduleIoOe, r;
	logic [9:0]  q[$], e;
	logic [7:0]  prev = 0;
	int          bad_count = 0, checked = 0, k, c;
	cat_counter_array DUT (.clk, .sys_rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .cpuIdle, .globalIrqEnable, .t0Ovf,
		.extCountIn, .extOscIn, .moduleIoIn, .irqReq, .moduleIoOut,
		.moduleIoOe, .watchdogMode);
	initial forever #5 clk = ~clk;
	task give_verdict;
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] x, logic [31:0] s);
		checked++;
		if (s !== x) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask
	task bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask
	// Bit 9 skips the check, bit 8 compares the change since last read
	task rd(logic [7:0] a, logic [9:0] x);
		q.push_back(x);
		bus(0, a, 0);
	endtask
	task stim(int s, int n);
		repeat (n) begin
			if (s == 2 || s == 6) t0Ovf <= 1;
			@(posedge clk);
			t0Ovf <= 0;
			if (s == 3 || s == 6) extCountIn <= 0;
			repeat (4) @(posedge clk);
			extCountIn <= 1;
			repeat (4) @(posedge clk);
			if (s == 5 || s == 6) repeat (16) begin
				extOscIn <= ~extOscIn;
				repeat (2) @(posedge clk);
			end
		end
		repeat (8) @(posedge clk);
	endtask
	always @(posedge clk) begin
		if (rdPh) begin
			e = q.pop_front();
			if (e[8])
				chk("delta", e[7:0], 8'(hrdata[7:0] - prev));
			else if (!e[9])
				chk("hrdata", {24'h0, e[7:0]}, hrdata);
			prev <= hrdata[7:0];
		end
		rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	initial begin
		#200000;
		bad_count++;
		give_verdict;
	end
	initial begin
		k = $urandom(32'h582049bd);
		r = 6'($urandom);
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		moduleIoIn <= r;
		rd(8'h08, 10'h020);
		rd(8'h18, 10'h000);
		rd(8'h14, {4'h0, r});
		bus(1, 8'h10, r);
		@(posedge clk);
		#1 chk("ioOe", r, moduleIoOe);
		bus(1, 8'h4c, 32'h5a);
		rd(8'h4c, 10'h05a);
		rd(8'h8c, 10'h000);
		bus(1, 8'h08, 32'h00);
		bus(1, 8'h08, 32'h04);
		bus(1, 8'h00, 32'hff);
		bus(1, 8'h04, 32'h12);
		rd(8'h00, 10'h0ff);
		stim(2, 1);
		rd(8'h04, 10'h012);
		rd(8'h00, 10'h000);
		rd(8'h04, 10'h013);
		bus(1, 8'h00, 32'hff);
		bus(1, 8'h04, 32'hff);
		bus(1, 8'h08, 32'h05);
		bus(1, 8'h0c, 32'h01);
		globalIrqEnable <= 1;
		stim(2, 1);
		chk("irqReq", 1, irqReq);
		rd(8'h0c, 10'h081);
		globalIrqEnable <= 0;
		repeat (3) @(posedge clk);
		chk("irqReq", 0, irqReq);
		globalIrqEnable <= 1;
		bus(1, 8'h08, 32'h04);
		@(posedge clk);
		#1 chk("irqReq", 0, irqReq);
		rd(8'h0c, 10'h081);
		bus(1, 8'h0c, 32'h01);
		rd(8'h0c, 10'h001);
		cpuIdle <= 1;
		k = $urandom_range(1, 8);
		stim(2, k);
		rd(8'h00, k);
		bus(1, 8'h08, 32'h84);
		stim(2, k);
		rd(8'h00, k);
		cpuIdle <= 0;
		bus(1, 8'h08, 32'h24);
		bus(1, 8'h00, 32'h55);
		rd(8'h00, k);
		bus(1, 8'h08, 32'h00);
		rd(8'h08, 10'h004);
		for (c = 2; c < 7; c++) if (c != 4) begin
			bus(1, 8'h08, c << 1);
			bus(1, 8'h00, 32'h00);
			k = $urandom_range(1, 6);
			stim(c, k);
			rd(8'h00, (c == 6) ? 0 : k);
		end
		for (c = 0; c < 3; c++) begin
			bus(1, 8'h08, (c == 2 ? 4 : c) << 1);
			rd(8'h00, 10'h200);
			repeat (117) @(posedge clk);
			rd(8'h00, 10'h100 | (c == 0 ? 10 : c == 1 ? 30 : 120));
		end
		repeat (4) @(posedge clk);
		give_verdict;
	end
endmodule
`default_nettype wire
